// >>> dv/rscl_board_model.sv
// Board reset supervisor model with open-drain pin resolution
`timescale 1ns/1ps
module rscl_board_model (
  // Bench commands
  input wire logic holdHard,
  input wire logic holdSoft,
  // Device pin drivers
  input wire logic hard_reset_n_out,
  input wire logic hard_reset_n_oe,
  input wire logic soft_reset_n_out,
  input wire logic soft_reset_n_oe,
  // Resolved wires
  output logic hardPin,
  output logic softPin
);
  // Pull-ups lift a released pin, so a stale level never shows
  assign hardPin = !(holdHard || (hard_reset_n_oe && !hard_reset_n_out));
  assign softPin = !(holdSoft || (soft_reset_n_oe && !soft_reset_n_out));
endmodule

// >>> dv/rscl_reset_sequencer_tb.sv
// Testbench for the reset sequencer and configuration latch
`timescale 1ns/1ps
module rscl_reset_sequencer_tb;
  import rscl_pkg::*;
  // Short stretch keeps the run brief
  localparam int ST = 16;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic porN = 1'b0;
  logic holdHard = 1'b0;
  logic holdSoft = 1'b0;
  logic [RSCL_CFG_W-1:0] strap = 32'hA5C3_0F01;
  logic hardPin, softPin, hOut, hOe, sOut, sOe, hInt, sInt, locked;
  logic [RSCL_CFG_W-1:0] word;
  int failures = 0;
  int total_checks = 0;
  // ==========================================
  // Clock, partner and design
  always #2.5 sys_clk = ~sys_clk;
  rscl_board_model board (.holdHard(holdHard), .holdSoft(holdSoft),
    .hard_reset_n_out(hOut), .hard_reset_n_oe(hOe), .soft_reset_n_out(sOut),
    .soft_reset_n_oe(sOe), .hardPin(hardPin), .softPin(softPin));
  rscl_reset_sequencer #(.STRETCH(ST)) DUT (.sys_clk(sys_clk), .rst(rst),
    .power_on_reset_n(porN), .hard_reset_n_in(hardPin), .hard_reset_n_out(hOut),
    .hard_reset_n_oe(hOe), .soft_reset_n_in(softPin), .soft_reset_n_out(sOut),
    .soft_reset_n_oe(sOe), .cfgStrap(strap), .hardResetInt(hInt),
    .softResetInt(sInt), .cfgLocked(locked), .cfgWord(word));
  // ==========================================
  // Helpers
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // Sample a little after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait for the internal hard reset to reach a level
  task automatic wait_hard(input logic v, output int n);
    n = 0;
    while (hInt !== v && n < ST + 40) begin
      tick(1);
      n++;
    end
    check(n < ST + 40, "hard reset wait timed out");
    if (n >= ST + 40) results();
  endtask
  // ==========================================
  // Scenarios
  task automatic power_up();
    int n;
    tick(4);
    check(word === 32'hA5C3_0F01 && locked === 1'b0, "straps not loaded");
    check(hardPin === 1'b0 && softPin === 1'b0, "pins not driven");
    @(posedge sys_clk) porN <= 1'b1;
    wait_hard(1'b0, n);
    check(n >= ST && n <= ST + 5, "stretch length wrong");
    check(hardPin === 1'b1 && softPin === 1'b1, "pins still low");
    // Pins rise at stretch end; two sync edges and two lock edges follow
    tick(4);
    check(locked === 1'b1 && word === 32'hA5C3_0F01, "word not locked after release");
    strap <= 32'h0000_00FF;
    tick(3);
    check(word === 32'hA5C3_0F01 && locked === 1'b1, "word not frozen");
  endtask
  task automatic hard_pulse(input int len, input logic valid);
    int n;
    logic seen;
    logic [RSCL_CFG_W-1:0] seenWord;
    @(posedge sys_clk) holdHard <= 1'b1;
    strap <= 32'h1234_5678;
    tick(len - 1);
    // Sample off the edge, before the release
    seen = hInt;
    seenWord = word;
    @(posedge sys_clk) holdHard <= 1'b0;
    if (valid) begin
      check(seen === 1'b1 && seenWord === 32'h1234_5678, "hard reset not taken");
      tick(2);
      check(locked === 1'b0, "locked too early");
      tick(6);
      check(locked === 1'b1, "not locked after release");
      strap <= 32'h0000_0000;
      wait_hard(1'b0, n);
      check(n >= ST - 8 && n <= ST + 2, "hard stretch wrong");
      check(word === 32'h1234_5678, "word changed after lock");
    end else begin
      tick(10);
      check(seen === 1'b0 && hInt === 1'b0, "short hard pulse taken");
    end
  endtask
  task automatic soft_pulse(input int len, input logic valid);
    logic seen;
    @(posedge sys_clk) holdSoft <= 1'b1;
    tick(len - 1);
    seen = sInt;
    @(posedge sys_clk) holdSoft <= 1'b0;
    check(seen === valid && hInt === 1'b0, "soft pulse response wrong");
    tick(6);
    check(sInt === 1'b0, "soft reset stuck");
  endtask
  task automatic por_again();
    int n;
    @(posedge sys_clk) porN <= 1'b0;
    tick(6);
    check(hInt === 1'b1 && hardPin === 1'b0, "power-on reset ignored");
    @(posedge sys_clk) porN <= 1'b1;
    wait_hard(1'b0, n);
    check(n >= ST && n <= ST + 5, "second stretch wrong");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    power_up();
    hard_pulse(8, 1'b1);
    hard_pulse(2, 1'b0);
    soft_pulse(8, 1'b1);
    soft_pulse(2, 1'b0);
    por_again();
    results();
  end
endmodule

// >>> rtl/rscl_cfg_reg.sv
// Configuration word register with load enable and registered read data
`timescale 1ns/1ps
module rscl_cfg_reg
  import rscl_pkg::*;
#(
  parameter int WIDTH = RSCL_CFG_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Load side
  input wire logic load,
  input wire logic [WIDTH-1:0] strapIn,
  // Stored word
  output logic [WIDTH-1:0] word
);
  typedef struct packed {
    logic [WIDTH-1:0] word;
  } rscl_cfg_state_t;

  rscl_cfg_state_t st;
  rscl_cfg_state_t next_st;

  // Hold the word unless a load is asked for
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.word = strapIn;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word = st.word;
endmodule

// >>> rtl/rscl_pkg.sv
// Package: constants and types for the reset sequencer and configuration latch
package rscl_pkg;
  // =====================================================
  // Timing, widths and counter constants
  localparam int RSCL_STRETCH_CYCLES = 4096;
  localparam int RSCL_MIN_PULSE_CYCLES = 4;
  localparam int RSCL_LOCK_DELAY_CYCLES = 2;
  localparam int RSCL_CNT_W = 13;
  localparam int RSCL_CFG_W = 32;
  localparam logic [RSCL_CNT_W-1:0] RSCL_CNT_ZERO = 13'h0000;
  localparam logic [RSCL_CNT_W-1:0] RSCL_CNT_ONE = 13'h0001;
  localparam logic [2:0] RSCL_SHORT_ZERO = 3'h0;
  localparam logic [2:0] RSCL_SHORT_ONE = 3'h1;
  localparam logic [1:0] RSCL_SYNC_ASSERTED = 2'h0;

  // =====================================================
  // Sequencer states
  typedef enum logic [3:0] {
    RSCL_POWER_ON = 4'h1,
    RSCL_STRETCH = 4'h2,
    RSCL_RUN = 4'h4,
    RSCL_HARD_HELD = 4'h8
  } rscl_state_t;

  // Pin bundle for one two-way reset pin
  typedef struct packed {
    logic out;
    logic oe;
  } rscl_pin_t;
endpackage

// >>> rtl/rscl_reset_sequencer.sv
// Reset sequencer: pin synchronisers, reset stretching and configuration word lock
`timescale 1ns/1ps
module rscl_reset_sequencer
  import rscl_pkg::*;
#(
  parameter int STRETCH = RSCL_STRETCH_CYCLES,
  parameter int MIN_PULSE = RSCL_MIN_PULSE_CYCLES,
  parameter int CFG_W = RSCL_CFG_W
) (
  // Clock and chip reset
  input wire logic sys_clk,
  input wire logic rst,
  // Reset pins (power-on is input only, the other two are two-way)
  input wire logic power_on_reset_n,
  input wire logic hard_reset_n_in,
  output logic hard_reset_n_out,
  output logic hard_reset_n_oe,
  input wire logic soft_reset_n_in,
  output logic soft_reset_n_out,
  output logic soft_reset_n_oe,
  // Configuration straps
  input wire logic [CFG_W-1:0] cfgStrap,
  // Internal reset outputs and configuration word
  output logic hardResetInt,
  output logic softResetInt,
  output logic cfgLocked,
  output logic [CFG_W-1:0] cfgWord
);
  // =====================================================
  // State
  typedef struct packed {
    logic [1:0] porSync;
    logic [1:0] hardSync;
    logic [1:0] softSync;
    rscl_state_t fsm;
    logic [RSCL_CNT_W-1:0] cnt;
    logic [2:0] hardLow;
    logic [2:0] softLow;
    logic [1:0] lockCnt;
    logic locked;
    logic hardInt;
    logic softInt;
    logic drivePins;
  } rscl_seq_state_t;

  rscl_seq_state_t st;
  rscl_seq_state_t next_st;
  logic porLow;
  logic hardLowNow;
  logic softLowNow;
  logic cfgLoad;

  // Saturating low-time counter for the pulse width checks
  function automatic logic [2:0] bump(input logic [2:0] v, input logic low);
    if (!low) begin
      bump = RSCL_SHORT_ZERO;
    end else if (v == 3'(MIN_PULSE)) begin
      bump = v;
    end else begin
      bump = v + RSCL_SHORT_ONE;
    end
  endfunction

  // Synchronised pin levels; only the second stage is looked at
  assign porLow = ~st.porSync[1];
  assign hardLowNow = ~st.hardSync[1];
  assign softLowNow = ~st.softSync[1];

  // Sequencer next state
  always_comb begin
    next_st = st;
    next_st.porSync = {st.porSync[0], power_on_reset_n};
    next_st.hardSync = {st.hardSync[0], hard_reset_n_in};
    next_st.softSync = {st.softSync[0], soft_reset_n_in};
    // Own drive does not count as an external pulse
    next_st.hardLow = bump(st.hardLow, hardLowNow && !st.drivePins);
    next_st.softLow = bump(st.softLow, softLowNow && !st.drivePins);
    next_st.softInt = st.hardInt;
    if (st.softLow == 3'(MIN_PULSE) && softLowNow) begin
      next_st.softInt = 1'b1;
    end
    unique case (st.fsm)
      RSCL_POWER_ON: begin
        next_st.hardInt = 1'b1;
        next_st.drivePins = 1'b1;
        next_st.cnt = RSCL_CNT_ZERO;
        if (!porLow) begin
          next_st.fsm = RSCL_STRETCH;
        end
      end
      RSCL_STRETCH: begin
        next_st.hardInt = 1'b1;
        next_st.cnt = st.cnt + RSCL_CNT_ONE;
        if (st.cnt == RSCL_CNT_W'(STRETCH - 1)) begin
          next_st.fsm = RSCL_RUN;
          next_st.drivePins = 1'b0;
          next_st.hardInt = 1'b0;
        end
      end
      RSCL_RUN: begin
        next_st.hardInt = 1'b0;
        if (st.hardLow == 3'(MIN_PULSE) && hardLowNow) begin
          next_st.fsm = RSCL_HARD_HELD;
          next_st.hardInt = 1'b1;
        end
      end
      RSCL_HARD_HELD: begin
        next_st.hardInt = 1'b1;
        next_st.cnt = RSCL_CNT_ZERO;
        if (!hardLowNow) begin
          next_st.fsm = RSCL_STRETCH;
        end
      end
      default: begin
        next_st.fsm = RSCL_POWER_ON;
      end
    endcase
    // Power-on reset overrides the state, internal hard reset and pin drive, whatever the state
    if (porLow) begin
      next_st.fsm = RSCL_POWER_ON;
      next_st.hardInt = 1'b1;
      next_st.drivePins = 1'b1;
    end
    // Lock countdown starts only once both synchronised resets are high
    if (porLow || hardLowNow) begin
      next_st.lockCnt = RSCL_SYNC_ASSERTED;
      next_st.locked = 1'b0;
    end else if (!st.locked) begin
      next_st.lockCnt = st.lockCnt + 2'h1;
      if (st.lockCnt == 2'(RSCL_LOCK_DELAY_CYCLES - 1)) begin
        next_st.locked = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '{porSync: 2'h0, hardSync: 2'h0, softSync: 2'h0, fsm: RSCL_POWER_ON,
              cnt: RSCL_CNT_ZERO, hardLow: RSCL_SHORT_ZERO, softLow: RSCL_SHORT_ZERO,
              lockCnt: 2'h0, locked: 1'b0, hardInt: 1'b1, softInt: 1'b1, drivePins: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // Straps keep loading until the lock; the word lags the straps one edge.
  // A fresh reset loads at once, so the edge that clears the lock is not lost.
  assign cfgLoad = !st.locked || porLow || hardLowNow;

  rscl_cfg_reg #(
    .WIDTH(CFG_W)
  ) u_cfg (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(cfgLoad),
    .strapIn(cfgStrap),
    .word(cfgWord)
  );

  // Pins are open-drain style: driven low only in power-on reset and the stretch after it, not after a hard reset
  assign hard_reset_n_out = 1'b0;
  assign soft_reset_n_out = 1'b0;
  assign hard_reset_n_oe = st.drivePins;
  assign soft_reset_n_oe = st.drivePins;
  assign hardResetInt = st.hardInt;
  assign softResetInt = st.softInt;
  assign cfgLocked = st.locked;

  // =====================================================
  // Checks
  stretch_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st.fsm == RSCL_STRETCH && st.cnt == RSCL_CNT_ZERO && !porLow && st.drivePins) |-> hard_reset_n_oe [*8])
    else $error("pins released too early in stretch");
  por_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    porLow |=> hard_reset_n_oe && soft_reset_n_oe)
    else $error("pins not driven during power-on reset");
  hard_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st.fsm == RSCL_HARD_HELD) |-> hardResetInt)
    else $error("internal reset dropped while hard reset held");
  stretch_int_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(hardResetInt) |-> $past(st.cnt) == RSCL_CNT_W'(STRETCH - 1))
    else $error("internal reset ended before full stretch");
  cfg_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (porLow || hardLowNow) |=> cfgWord == $past(cfgStrap))
    else $error("straps not sampled during reset");
  cfg_freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!porLow && !hardLowNow && !st.locked && st.lockCnt == RSCL_SYNC_ASSERTED
     && !$past(porLow || hardLowNow) == 1'b0) |-> ##2 cfgLocked)
    else $error("word not locked two cycles after release");
  cfg_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cfgLocked && $past(cfgLocked)) |-> $stable(cfgWord))
    else $error("locked word changed");
  sync_order_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(power_on_reset_n) |-> ##1 porLow)
    else $error("power-on release not delayed by synchroniser");
endmodule
